// *** src/autoneg_partner_nextpage_regs.sv ***
// partner ability, expansion and next page registers on classic wishbone
`timescale 1ns/1ps
`include "an_regs_params.svh"

// Behaviour
// - partner ability bit 15 shows partner wants next page exchange
// - partner ability bit 14 shows partner received our link code word
// - partner remote fault copied into ability bit 13, no other action
// - ability bits 4:0 hold partner selector, cleared on restart or reset
// - ability bits 9:5 show partner modes, cleared on restart or reset
// - partner pause field mirrors pause bit of received ability word
// - expansion bit 4 latches parallel detect fault, clears on read/reset
// - expansion bit 3 always equals partner ability bit 15
// - expansion bit 2 is read-only and always one
// - expansion bit 1 latches on any received base or next page, even one arriving with restart, holds until reset
// - expansion bit 0 set only once partner known auto-negotiation able
// - transmit bit 15 written one if more pages follow, resets zero
// - transmit bit 13 selects message page, resets to one
// - transmit bit 12 writable comply flag, resets zero
// - transmit bit 11 read-only toggle, inverse of last sent toggle
// - toggle alternates on each next page sent
// - transmit bits 10:0 hold eleven-bit message or unformatted code
// - received bit 15 shows partner wants more next pages
// - received bit 14 shows partner acknowledge, resets zero
// - received bits 13 and 12 show partner page type and comply
// - received bit 11 partner toggle, bits 10:0 partner code
module autoneg_partner_nextpage_regs
  import an_regs_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // wishbone classic slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  // auto-negotiation state machine
  input  wire logic        an_restart_i,
  input  wire logic        base_page_rx_i,
  input  wire logic        next_page_rx_i,
  input  wire logic [15:0] rx_word_i,
  input  wire logic        pd_fault_i,
  input  wire logic        partner_not_able_i,
  input  wire logic        next_page_sent_i,
  output logic      [15:0] np_tx_word_o,
  output logic             np_loaded_o
);

  // bus state
  logic        ack_ff;
  logic [31:0] rdata_ff;

  // partner and next page storage
  page_word_t  ability_ff;
  page_word_t  np_rx_ff;
  logic        npt_more_ff;
  logic        npt_msg_ff;
  logic        npt_comply_ff;
  logic [10:0] npt_code_ff;
  logic        toggle_ff;
  logic        loaded_ff;

  // next values
  page_word_t  nxt_ability;
  page_word_t  nxt_np_rx;
  logic        nxt_toggle;
  logic        nxt_loaded;
  logic [31:0] nxt_rdata;

  // decode
  logic        req;
  logic        rd_req;
  logic        wr_req;
  logic [5:0]  reg_idx;
  reg_select_t reg_sel;
  logic        wr_npt;
  logic        wr_npt_lo;
  logic        wr_npt_hi;
  logic        rd_exp;
  logic        base_take;

  // read views
  page_word_t  expansion_view;
  page_word_t  npt_view;
  page_word_t  rd_word;

  // latched expansion flags
  logic [`NUM_STICKY-1:0] sticky_set;
  logic [`NUM_STICKY-1:0] sticky_clr;
  logic [`NUM_STICKY-1:0] sticky_q;

  // reset constants held as typed values so they can be sliced
  localparam logic [10:0] NPT_CODE_RST = `RST_NPT_CODE;
  localparam logic [2:0]  NPT_CTRL_RST = `RST_NPT_CTRL;

  // new request: first cycle of cyc&stb, ack answers in the next
  // ack_ff masks the held strobe so one request is taken once
  assign req     = cyc_i & stb_i & ~ack_ff;
  assign rd_req  = req & ~we_i;
  assign wr_req  = req & we_i;
  assign reg_idx = adr_i[7:2];

  assign reg_sel =
    (reg_idx == `IDX_PARTNER_ABILITY)     ? REG_ABILITY :
    (reg_idx == `IDX_AUTONEG_EXPANSION)   ? REG_EXPANSION :
    (reg_idx == `IDX_NEXT_PAGE_TRANSMIT)  ? REG_NP_TRANSMIT :
    (reg_idx == `IDX_PARTNER_NP_RECEIVED) ? REG_NP_RECEIVED :
    REG_NONE;

  assign wr_npt    = wr_req & (reg_sel == REG_NP_TRANSMIT);
  assign wr_npt_lo = wr_npt & sel_i[0];
  assign wr_npt_hi = wr_npt & sel_i[1];
  assign rd_exp    = rd_req & (reg_sel == REG_EXPANSION);

  // restart discards a base page arriving in the same cycle
  assign base_take = base_page_rx_i & ~an_restart_i;

  // expansion flag sources
  // page rx has no clear source: it only drops on chip reset
  assign sticky_set[0] = pd_fault_i;
  assign sticky_clr[0] = rd_exp;
  assign sticky_set[1] = base_page_rx_i | next_page_rx_i;
  assign sticky_clr[1] = 1'b0;
  assign sticky_set[2] = base_take;
  assign sticky_clr[2] = an_restart_i | partner_not_able_i;

  // one latched flag each for expansion bits 4, 1 and 0
  genvar g;
  generate
    for (g = 0; g < `NUM_STICKY; g = g + 1)
    begin : g_sticky
      sticky_flag u_flag
      (
        .clk_i  (clk_i),
        .rst_i  (rst_i),
        .set_i  (sticky_set[g]),
        .clr_i  (sticky_clr[g]),
        .flag_o (sticky_q[g])
      );
    end
  endgenerate

  // partner ability: whole base word captured, reserved bit masked
  // restart beats a base page landing in the same cycle
  // bits 15,14,13,10,9:5,4:0 copied straight
  always_comb
  begin
    nxt_ability = ability_ff;
    if (an_restart_i)
    begin
      nxt_ability = `RST_PAGE;
    end
    else if (base_page_rx_i)
    begin
      nxt_ability = rx_word_i & `ABIL_MASK;
    end
  end

  // received next page: one word, all fields at once
  always_comb
  begin
    nxt_np_rx = np_rx_ff;
    if (next_page_rx_i)
    begin
      nxt_np_rx = rx_word_i;
    end
  end

  // toggle flips for every page sent, restart starts over
  // no bus path: bit 11 of the transmit view is read-only
  always_comb
  begin
    nxt_toggle = toggle_ff;
    if (an_restart_i)
    begin
      nxt_toggle = `RST_TOGGLE;
    end
    else if (next_page_sent_i)
    begin
      nxt_toggle = ~toggle_ff;
    end
  end

  // page loaded until the machine sends it; a fresh write wins
  always_comb
  begin
    nxt_loaded = loaded_ff;
    // any write marks a page loaded, even with no lane selected
    if (wr_npt)
    begin
      nxt_loaded = 1'b1;
    end
    else if (next_page_sent_i | an_restart_i)
    begin
      nxt_loaded = 1'b0;
    end
  end

  // read views
  always_comb
  begin
    expansion_view                  = 16'h0000;
    expansion_view[`EXP_PD_FAULT]   = sticky_q[0];
    expansion_view[`EXP_NP_ABLE_LP] = ability_ff[`PG_NEXT_PAGE];
    expansion_view[`EXP_NP_ABLE]    = 1'b1;
    expansion_view[`EXP_PAGE_RX]    = sticky_q[1];
    expansion_view[`EXP_AN_ABLE_LP] = sticky_q[2];
  end

  always_comb
  begin
    npt_view                                = 16'h0000;
    npt_view[`PG_NEXT_PAGE]                 = npt_more_ff;
    npt_view[`PG_MSG_PAGE]                  = npt_msg_ff;
    npt_view[`PG_COMPLY_ACK]                = npt_comply_ff;
    npt_view[`PG_TOGGLE]                    = toggle_ff;
    npt_view[`PG_CODE_HI:0]                 = npt_code_ff;
  end

  assign rd_word =
    (reg_sel == REG_ABILITY)     ? ability_ff :
    (reg_sel == REG_EXPANSION)   ? expansion_view :
    (reg_sel == REG_NP_TRANSMIT) ? npt_view :
    (reg_sel == REG_NP_RECEIVED) ? np_rx_ff :
    16'h0000;

  // unmapped reads give zero, upper half always zero
  // the only read side effect is the pd fault clear above
  assign nxt_rdata = rd_req ? {16'h0000, rd_word} : rdata_ff;

  // bus answer
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ack_ff   <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff   <= req;
      rdata_ff <= nxt_rdata;
    end
  end

  // partner ability word
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ability_ff <= `RST_PAGE;
    end
    else
    begin
      ability_ff <= nxt_ability;
    end
  end

  // received next page word; restart leaves the last page readable
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      np_rx_ff <= `RST_PAGE;
    end
    else
    begin
      np_rx_ff <= nxt_np_rx;
    end
  end

  // next page transmit low byte: code bits 7:0
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      npt_code_ff[7:0] <= NPT_CODE_RST[7:0];
    end
    else if (wr_npt_lo)
    begin
      npt_code_ff[7:0] <= dat_i[7:0];
    end
  end

  // next page transmit high byte: control bits and code bits 10:8
  // lane 1 bits 14 and 11 are dropped: reserved and read-only
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      npt_code_ff[10:8] <= NPT_CODE_RST[10:8];
      npt_more_ff       <= NPT_CTRL_RST[2];
      npt_msg_ff        <= NPT_CTRL_RST[1];
      npt_comply_ff     <= NPT_CTRL_RST[0];
    end
    else if (wr_npt_hi)
    begin
      npt_code_ff[10:8] <= dat_i[10:8];
      npt_more_ff       <= dat_i[`PG_NEXT_PAGE];
      npt_msg_ff        <= dat_i[`PG_MSG_PAGE];
      npt_comply_ff     <= dat_i[`PG_COMPLY_ACK];
    end
  end

  // toggle state
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      toggle_ff <= `RST_TOGGLE;
    end
    else
    begin
      toggle_ff <= nxt_toggle;
    end
  end

  // page loaded state for the negotiation machine
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      loaded_ff <= 1'b0;
    end
    else
    begin
      loaded_ff <= nxt_loaded;
    end
  end

  // outputs straight from registers and their views
  assign dat_o        = rdata_ff;
  assign ack_o        = ack_ff;
  assign np_tx_word_o = npt_view;
  assign np_loaded_o  = loaded_ff;

endmodule // autoneg_partner_nextpage_regs

// *** src/an_regs_params.svh ***
// offsets, field positions and reset values of the partner/next page regs
`ifndef AN_REGS_PARAMS_SVH
`define AN_REGS_PARAMS_SVH

// register indexes; byte address is four times the index
`define IDX_PARTNER_ABILITY    6'h05
`define IDX_AUTONEG_EXPANSION  6'h06
`define IDX_NEXT_PAGE_TRANSMIT 6'h07
`define IDX_PARTNER_NP_RECEIVED 6'h08

// common page word layout
`define PG_NEXT_PAGE   15
`define PG_ACK         14
`define PG_MSG_PAGE    13
`define PG_REMOTE_FLT  13
`define PG_COMPLY_ACK  12
`define PG_TOGGLE      11
`define PG_PAUSE       10
`define PG_CODE_HI     10
`define PG_ABIL_HI     9
`define PG_ABIL_LO     5
`define PG_SEL_HI      4

// partner ability: bit 12 reserved, reads zero
`define ABIL_MASK      16'hefff

// expansion register bits
`define EXP_PD_FAULT   4
`define EXP_NP_ABLE_LP 3
`define EXP_NP_ABLE    2
`define EXP_PAGE_RX    1
`define EXP_AN_ABLE_LP 0

// latched expansion flags: 0 = pd fault, 1 = page rx, 2 = partner an able
`define NUM_STICKY     3

// reset values
`define RST_PAGE       16'h0000
`define RST_NPT_CTRL   3'b010
`define RST_NPT_CODE   11'h001
`define RST_TOGGLE     1'b0

`endif

// *** src/an_regs_pkg.sv ***
// types shared by the partner/next page register block
package an_regs_pkg;

  typedef logic [15:0] page_word_t;

  typedef enum logic [2:0] {
    REG_NONE,
    REG_ABILITY,
    REG_EXPANSION,
    REG_NP_TRANSMIT,
    REG_NP_RECEIVED
  } reg_select_t;

endpackage

// *** src/sticky_flag.sv ***
// latched status bit: set wins over clear
`timescale 1ns/1ps
module sticky_flag
(
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic set_i,
  input  wire logic clr_i,
  output logic      flag_o
);

  logic flag_ff;
  logic nxt_flag;

  assign nxt_flag = set_i | (flag_ff & ~clr_i);
  assign flag_o   = flag_ff;

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      flag_ff <= 1'b0;
    end
    else
    begin
      flag_ff <= nxt_flag;
    end
  end

endmodule // sticky_flag

// *** testbench/an_regs_assertions.sv ***
// port checker for the partner/next page register block
`timescale 1ns/1ps
`include "an_regs_params.svh"
module an_regs_assertions
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [7:0]  adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic        an_restart_i,
  input wire logic        next_page_sent_i,
  input wire logic [15:0] np_tx_word_o,
  input wire logic        np_loaded_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take  = cyc_i && stb_i && !ack_o;
  wire wr_np = take && we_i && adr_i[7:2] == `IDX_NEXT_PAGE_TRANSMIT;
  wire rd_ex = take && !we_i && adr_i[7:2] == `IDX_AUTONEG_EXPANSION;
  wire flip  = next_page_sent_i && !an_restart_i;

  a_ack_pulse: assert property (take |=> ack_o ##1 !ack_o)
    else $error("ack not one pulse");
  a_exp_fixed: assert property (
    rd_ex |=> dat_o[31:5] == 27'h0 && dat_o[2])
    else $error("expansion fixed bits wrong");
  a_tx_write: assert property (
    wr_np && sel_i[1:0] == 2'b11 |=>
    ((np_tx_word_o ^ $past(dat_i[15:0])) & 16'hb7ff) == 16'h0000)
    else $error("transmit word not written");
  a_tx_keep: assert property (
    !wr_np |=> $stable(np_tx_word_o & 16'hb7ff))
    else $error("transmit word changed");
  a_toggle_flip: assert property (
    flip |=> np_tx_word_o[11] != $past(np_tx_word_o[11]))
    else $error("toggle did not flip");
  a_toggle_hold: assert property (
    !next_page_sent_i && !an_restart_i |=>
    $stable(np_tx_word_o[11]))
    else $error("toggle moved");
  a_restart_tog: assert property (an_restart_i |=> !np_tx_word_o[11])
    else $error("toggle not cleared");
  a_load_set: assert property (wr_np |=> np_loaded_o)
    else $error("loaded flag not set");
  a_load_clr: assert property (
    (flip || an_restart_i) && !wr_np |=> !np_loaded_o)
    else $error("loaded flag not cleared");

  c_np_write: cover property (wr_np);
  c_np_sent: cover property (next_page_sent_i && np_loaded_o);
  c_exp_read: cover property (rd_ex);
endmodule // an_regs_assertions

bind autoneg_partner_nextpage_regs an_regs_assertions i_chk (
  .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
  .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
  .dat_o(dat_o), .ack_o(ack_o), .an_restart_i(an_restart_i),
  .next_page_sent_i(next_page_sent_i), .np_tx_word_o(np_tx_word_o),
  .np_loaded_o(np_loaded_o));

// *** testbench/an_partner_model.sv ***
// far side: negotiation events in, transmit pages taken out
`timescale 1ns/1ps
module an_partner_model
(
  input  wire logic        clk_i,
  input  wire logic [15:0] np_tx_word_i,
  input  wire logic        np_loaded_i,
  output logic             an_restart_o,
  output logic             base_page_rx_o,
  output logic             next_page_rx_o,
  output logic      [15:0] rx_word_o,
  output logic             pd_fault_o,
  output logic             partner_not_able_o,
  output logic             next_page_sent_o
);
  int          lat = 0;
  int          cnt = 0;
  logic [15:0] sent_w = 16'h0000;
  initial
  begin
    {an_restart_o, base_page_rx_o, next_page_rx_o} = 3'b000;
    {pd_fault_o, partner_not_able_o} = 2'b00;
    rx_word_o = 16'h0000;
  end
  // one-cycle event; word inverted once no longer valid
  task automatic drive(input logic [4:0] ev, input logic [15:0] w);
    @(posedge clk_i);
    {an_restart_o, base_page_rx_o, next_page_rx_o, pd_fault_o,
     partner_not_able_o} <= ev;
    rx_word_o <= w;
    @(posedge clk_i);
    {an_restart_o, base_page_rx_o, next_page_rx_o, pd_fault_o,
     partner_not_able_o} <= 5'h00;
    rx_word_o <= ~w;
  endtask
  // takes a loaded page after lat cycles
  always @(posedge clk_i)
  begin
    next_page_sent_o <= 1'b0;
    if (np_loaded_i !== 1'b1 || next_page_sent_o)
      cnt <= 0;
    else if (cnt >= lat)
    begin
      next_page_sent_o <= 1'b1;
      sent_w <= np_tx_word_i;
      cnt <= 0;
    end
    else
      cnt <= cnt + 1;
  end
endmodule // an_partner_model

// *** testbench/testbench.sv ***
// self-checking bench for the partner/next page register block
`timescale 1ns/1ps
module testbench;
  logic        clk_i, rst_i, cyc_i, stb_i, we_i, ack_o, np_loaded_o;
  logic        an_restart_i, base_page_rx_i, next_page_rx_i;
  logic        pd_fault_i, partner_not_able_i, next_page_sent_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [15:0] rx_word_i, np_tx_word_o;
  logic [31:0] dat_i, dat_o, q;
  int          n_errors = 0;
  int          n_tests = 0;

  autoneg_partner_nextpage_regs i_autoneg_partner_nextpage_regs (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .an_restart_i(an_restart_i),
    .base_page_rx_i(base_page_rx_i), .next_page_rx_i(next_page_rx_i),
    .rx_word_i(rx_word_i), .pd_fault_i(pd_fault_i),
    .partner_not_able_i(partner_not_able_i),
    .next_page_sent_i(next_page_sent_i), .np_tx_word_o(np_tx_word_o),
    .np_loaded_o(np_loaded_o));

  an_partner_model partner (
    .clk_i(clk_i), .np_tx_word_i(np_tx_word_o), .np_loaded_i(np_loaded_o),
    .an_restart_o(an_restart_i), .base_page_rx_o(base_page_rx_i),
    .next_page_rx_o(next_page_rx_i), .rx_word_o(rx_word_i),
    .pd_fault_o(pd_fault_i), .partner_not_able_o(partner_not_able_i),
    .next_page_sent_o(next_page_sent_i));

  task automatic stop_test;
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // classic cycle, entered just after a rising edge
  task automatic wb(input logic w, input logic [7:0] a,
                    input logic [15:0] d, input logic [3:0] s);
    {cyc_i, stb_i, we_i} <= {2'b11, w};
    adr_i <= a;
    sel_i <= s;
    dat_i <= {16'h0000, d};
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1);
    q = dat_o;
    {cyc_i, stb_i} <= 2'b00;
    @(posedge clk_i);
  endtask

  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 16'h0000, 4'h3);
    chk(q, exp);
  endtask

  // no local limit: only the watchdog ends a hung wait
  task automatic wait_sent;
    while (np_loaded_o !== 1'b0)
    begin
      @(posedge clk_i);
    end
    @(posedge clk_i);
  endtask

  initial
  begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i;
  end

  initial
  begin
    repeat (5000) @(posedge clk_i);
    n_errors++;
    stop_test;
  end

  initial
  begin
    {rst_i, cyc_i, stb_i, we_i} = 4'b1000;
    adr_i = 8'h00;
    sel_i = 4'h0;
    dat_i = 32'h0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rd(8'h18, 32'h0004);
    rd(8'h1c, 32'h2001);
    rd(8'h14, 32'h0000);
    rd(8'h20, 32'h0000);
    wb(1'b1, 8'h3c, 16'hffff, 4'h3);
    rd(8'h3c, 32'h0000);
    partner.drive(5'b01000, 16'hffff);
    wb(1'b1, 8'h14, 16'h0000, 4'h3);
    rd(8'h14, 32'hefff);
    rd(8'h18, 32'h000f);
    partner.drive(5'b01000, 16'h2a55);
    rd(8'h14, 32'h2a55);
    rd(8'h18, 32'h0007);
    partner.drive(5'b00010, 16'h0000);
    rd(8'h18, 32'h0017);
    rd(8'h18, 32'h0007);
    partner.drive(5'b00001, 16'h0000);
    rd(8'h18, 32'h0006);
    partner.drive(5'b01000, 16'h8001);
    partner.drive(5'b10000, 16'h0000);
    rd(8'h14, 32'h0000);
    rd(8'h18, 32'h0006);
    partner.drive(5'b00100, 16'hd8a5);
    rd(8'h20, 32'hd8a5);
    partner.drive(5'b00100, 16'h275a);
    wb(1'b1, 8'h20, 16'h0000, 4'h3);
    rd(8'h20, 32'h275a);
    partner.lat = 40;
    wb(1'b1, 8'h1c, 16'hf7ff, 4'h3);
    rd(8'h1c, 32'hb7ff);
    wait_sent;
    chk({16'h0000, partner.sent_w}, 32'hb7ff);
    rd(8'h1c, 32'hbfff);
    partner.lat = 0;
    wb(1'b1, 8'h1c, 16'h0000, 4'h3);
    wait_sent;
    chk({16'h0000, partner.sent_w}, 32'h0800);
    rd(8'h1c, 32'h0000);
    partner.lat = 40;
    wb(1'b1, 8'h1c, 16'hffff, 4'h1);
    rd(8'h1c, 32'h00ff);
    chk({31'h0, np_loaded_o}, 32'h1);
    partner.drive(5'b10000, 16'h0000);
    rd(8'h1c, 32'h00ff);
    chk({31'h0, np_loaded_o}, 32'h0);
    wb(1'b1, 8'h1c, 16'h4800, 4'h2);
    rd(8'h1c, 32'h00ff);
    chk({31'h0, np_loaded_o}, 32'h1);
    stop_test;
  end
endmodule // testbench
